//--- design/wss_pkg.sv
// shared constants and mode types for the weld sequence supervisor
package wss_pkg;

  // input synchroniser layout
  localparam int SYNC_W       = 11;
  localparam int SY_INIT1     = 0;
  localparam int SY_INIT2     = 1;
  localparam int SY_STAGE2    = 2;
  localparam int SY_ESCAPE    = 3;
  localparam int SY_RETRACT   = 4;
  localparam int SY_ERR_RST   = 5;
  localparam int SY_LINE      = 6;
  localparam int SY_SEL0      = 7;

  // field widths
  localparam int PH_W         = 7;
  localparam int SCHED_W      = 6;
  localparam int VOLT_W       = 10;
  localparam int PART_W       = 16;
  localparam int WPP_W        = 14;
  localparam int EOS_W        = 26;

  // fixed schedule for the second initiation input
  localparam logic [SCHED_W-1:0] SCHED_SECOND = 6'h14;
  // phase setting that means wait for escape in wait-here cycle mode
  localparam logic [PH_W-1:0]    PH_INFINITE  = 7'h63;
  localparam logic [PH_W-1:0]    PH_ONE       = 7'h01;
  localparam logic [PH_W-1:0]    PH_MAX       = 7'h7F;

  // documented defaults of the programmable settings
  localparam logic [PART_W-1:0]  PART_LIMIT_DFLT = 16'hEA60;
  localparam logic [WPP_W-1:0]   WPP_DFLT        = 14'h0001;
  localparam logic [VOLT_W-1:0]  VOLT_HIGH_DFLT  = 10'h2B2;
  localparam logic [VOLT_W-1:0]  VOLT_LOW_DFLT   = 10'h0A0;

  // sequence-done pulse length
  localparam int CLK_HZ        = 100000000;
  localparam int EOS_PULSE_MS  = 500;
  localparam int EOS_CYC_DFLT  = EOS_PULSE_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {WM_SPOT, WM_SEAM_A, WM_SEAM_B} wss_weld_mode_t;
  typedef enum logic [1:0] {RT_OFF, RT_MAINTAINED, RT_MOMENTARY}
    wss_retract_mode_t;
  typedef enum logic [1:0] {EP_CONTINUE, EP_HEAD_LOCK, EP_STOP}
    wss_err_policy_t;
  typedef enum logic [1:0] {SS_NONE, SS_AFTER_SQZ, SS_BEFORE_SQZ}
    wss_stage2_mode_t;
  typedef enum logic [1:0] {BM_OFF, BM_SQUEEZE, BM_SQZ_WELD, BM_WAIT_HERE}
    wss_beat_mode_t;
  typedef enum logic {SD_PULSED, SD_HANDSHAKE} wss_done_mode_t;

endpackage : wss_pkg

//--- design/wss_sync.sv
// two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/1ns
module wss_sync
  import wss_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // raw and synchronised levels
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
  } wss_sync_state_t;

  wss_sync_state_t s_r;
  wss_sync_state_t s_nxt;

  // meta stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_bit
      always_comb
      begin
        s_nxt.meta[gi] = async_in[gi];
        s_nxt.sync[gi] = s_r.meta[gi];
      end
    end
  endgenerate

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sync_out = s_r.sync;

endmodule : wss_sync

//--- design/wss_tally.sv
// weld-per-part and part tallies with the part-count limit compare
`timescale 1ns/1ns
module wss_tally
  import wss_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire logic              weld_pulse,
  input  wire logic              count_en,
  input  wire logic [WPP_W-1:0]  welds_per_part,
  input  wire logic [PART_W-1:0] part_limit,
  input  wire logic              clr_part,
  input  wire logic              clr_weld,
  // tallies
  output logic      [WPP_W-1:0]  weld_tally,
  output logic      [PART_W-1:0] part_tally,
  output logic                   limit_hit
);

  typedef struct packed {
    logic [WPP_W-1:0]  weld;
    logic [PART_W-1:0] part;
    logic              hit;
  } wss_tally_state_t;

  wss_tally_state_t s_r;
  wss_tally_state_t s_nxt;
  logic [WPP_W-1:0] weld_inc;

  // counting; a clear request wins over a weld in the same cycle
  always_comb
  begin
    s_nxt    = s_r;
    weld_inc = WPP_W'(s_r.weld + 1'b1);
    if (weld_pulse && count_en)
    begin
      if (weld_inc >= welds_per_part)
      begin
        s_nxt.weld = '0;
        if (s_r.part != '1)
          s_nxt.part = PART_W'(s_r.part + 1'b1);
      end
      else
        s_nxt.weld = weld_inc;
    end
    if (clr_weld)
      s_nxt.weld = '0;
    if (clr_part)
      s_nxt.part = '0;
    s_nxt.hit = (s_nxt.part == part_limit);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign weld_tally = s_r.weld;
  assign part_tally = s_r.part;
  assign limit_hit  = s_r.hit;

endmodule : wss_tally

//--- design/wss_top.sv
// weld sequence supervisor: phase sequencing, beat, errors, outputs
`timescale 1ns/1ns
module wss_top
  import wss_pkg::*;
#(
  parameter int EOS_PULSE_CYC = EOS_CYC_DFLT
)
(
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       SYS_RST,
  // pins from operator or plc
  input  wire logic                       FIRST_INITIATE_INPUT,
  input  wire logic                       SECOND_INITIATE_INPUT,
  input  wire logic                       SCHEDULE_SELECT_BIT0,
  input  wire logic                       SCHEDULE_SELECT_BIT1,
  input  wire logic                       SCHEDULE_SELECT_BIT2,
  input  wire logic                       SCHEDULE_SELECT_BIT3,
  input  wire logic                       SECOND_STAGE_IN,
  input  wire logic                       ESCAPE_IN,
  input  wire logic                       RETRACT_IN,
  input  wire logic                       ERROR_RESET_IN,
  input  wire logic                       LINE_CYCLE_IN,
  // configuration
  input  wire wss_pkg::wss_weld_mode_t    WELD_MODE,
  input  wire wss_pkg::wss_retract_mode_t RETRACT_MODE,
  input  wire wss_pkg::wss_err_policy_t   ERROR_POLICY,
  input  wire logic                       SCHED_EXTERNAL,
  input  wire wss_pkg::wss_stage2_mode_t  STAGE2_MODE,
  input  wire wss_pkg::wss_beat_mode_t    BEAT_MODE,
  input  wire wss_pkg::wss_done_mode_t    SEQUENCE_DONE_MODE,
  input  wire logic                       CYCLE_WAIT_HERE,
  input  wire logic                       CHAIN_NEXT,
  input  wire logic [5:0]                 PROGRAM_SCHEDULE,
  // schedule timing in line cycles and the impulse count
  input  wire logic [6:0]                 SQZ_DELAY_CYC,
  input  wire logic [6:0]                 SQUEEZE_CYC,
  input  wire logic [6:0]                 WELD1_CYC,
  input  wire logic [6:0]                 COOL1_CYC,
  input  wire logic [6:0]                 WELD2_CYC,
  input  wire logic [6:0]                 COOL2_CYC,
  input  wire logic [6:0]                 HOLD_CYC,
  input  wire logic [6:0]                 OFF_CYC,
  input  wire logic [6:0]                 IMPULSES,
  input  wire logic [6:0]                 BLANKING_CYC,
  // supply voltage monitor
  input  wire logic                       VOLT_MON_EN,
  input  wire logic [9:0]                 VOLT_HIGH_LIMIT,
  input  wire logic [9:0]                 VOLT_LOW_LIMIT,
  input  wire logic [9:0]                 VOLT_MEAS,
  input  wire logic                       VOLT_VALID,
  // errors and counters
  input  wire logic                       MAJOR_ERROR,
  input  wire logic                       COUNTER_EN,
  input  wire logic [15:0]                PART_LIMIT,
  input  wire logic [13:0]                WELDS_PER_PART,
  input  wire logic                       RST_PART_TALLY,
  input  wire logic                       RST_WELD_TALLY,
  // actuator and status outputs
  output logic                            VALVE_OUT,
  output logic                            RETRACT_OUT,
  output logic                            SEQUENCE_DONE_OUTPUT,
  output logic                            WELD_ACTIVE,
  output logic                            MEAS_ENABLE,
  output logic [5:0]                      SCHEDULE_NUM,
  output logic                            WELD_LOCKOUT,
  output logic                            ERR_HIGH_VOLT,
  output logic                            ERR_LOW_VOLT,
  output logic                            ERR_PART_LIMIT,
  output logic [15:0]                     PART_TALLY,
  output logic [13:0]                     WELDS_PER_PART_TALLY
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_PRE, ST_SQZ_DELAY, ST_SQUEEZE, ST_WAIT_POST,
    ST_WELD1, ST_COOL1, ST_WELD2, ST_COOL2, ST_HOLD, ST_OFF,
    ST_HEAD_LOCK, ST_PAUSE
  } wss_state_t;

  typedef struct packed {
    wss_state_t         st;
    wss_state_t         resume;
    logic [PH_W-1:0]    ph_cnt;
    logic [PH_W-1:0]    imp_cnt;
    logic [PH_W-1:0]    blank_cnt;
    logic               src2;
    logic [SCHED_W-1:0] sched;
    logic               valve;
    logic               retract;
    logic               sequence_done_mode;
    logic [EOS_W-1:0]   eos_cnt;
    logic               lockout;
    logic               err_hv;
    logic               err_lv;
    logic               err_pl;
    logic               weld_pls;
    logic [SYNC_W-1:0]  prev;
  } wss_top_state_t;

  wss_top_state_t    s_r;
  wss_top_state_t    s_nxt;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sy;
  logic [SYNC_W-1:0] rise;
  logic [PH_W-1:0]   target;
  logic              ph_done;
  logic              init_lvl;
  logic              seam_eff;
  logic              in_sqz;
  logic              in_weld;
  logic              beat_drop;
  logic              hv_cond;
  logic              lv_cond;
  logic              limit_hit;
  logic              err_evt;

  assign raw = {SCHEDULE_SELECT_BIT3, SCHEDULE_SELECT_BIT2,
                SCHEDULE_SELECT_BIT1, SCHEDULE_SELECT_BIT0,
                LINE_CYCLE_IN, ERROR_RESET_IN, RETRACT_IN, ESCAPE_IN,
                SECOND_STAGE_IN, SECOND_INITIATE_INPUT,
                FIRST_INITIATE_INPUT};

  wss_sync u_sync (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .async_in (raw),
    .sync_out (sy)
  );

  wss_tally u_tally (
    .clk            (REF_CLK),
    .rst            (SYS_RST),
    .weld_pulse     (s_r.weld_pls),
    .count_en       (COUNTER_EN),
    .welds_per_part (WELDS_PER_PART),
    .part_limit     (PART_LIMIT),
    .clr_part       (RST_PART_TALLY),
    .clr_weld       (RST_WELD_TALLY),
    .weld_tally     (WELDS_PER_PART_TALLY),
    .part_tally     (PART_TALLY),
    .limit_hit      (limit_hit)
  );

  assign rise = sy & ~s_r.prev;

  // programmed length of the current phase
  always_comb
  begin
    case (s_r.st)
      ST_SQZ_DELAY: target = SQZ_DELAY_CYC;
      ST_SQUEEZE:   target = SQUEEZE_CYC;
      ST_WELD1:     target = WELD1_CYC;
      ST_COOL1:     target = COOL1_CYC;
      ST_WELD2:     target = WELD2_CYC;
      ST_COOL2:     target = COOL2_CYC;
      ST_HOLD:      target = HOLD_CYC;
      ST_OFF:       target = OFF_CYC;
      default:      target = '0;
    endcase
  end

  // qualifiers; a wait-here phase set to PH_INFINITE (99) waits for escape
  always_comb
  begin
    ph_done  = (CYCLE_WAIT_HERE && target == PH_INFINITE) ?
               rise[SY_ESCAPE] : (s_r.ph_cnt >= target);
    init_lvl = s_r.src2 ? sy[SY_INIT2] : sy[SY_INIT1];
    seam_eff = (WELD_MODE == WM_SEAM_A) ||
               (WELD_MODE == WM_SEAM_B && !s_r.src2);
    in_sqz   = (s_r.st == ST_WAIT_PRE) || (s_r.st == ST_SQZ_DELAY) ||
               (s_r.st == ST_SQUEEZE) || (s_r.st == ST_WAIT_POST);
    in_weld  = (s_r.st == ST_WELD1) || (s_r.st == ST_COOL1) ||
               (s_r.st == ST_WELD2) || (s_r.st == ST_COOL2);
    // wait-here beat only counts when the cycle mode agrees
    case (BEAT_MODE)
      BM_SQUEEZE:   beat_drop = in_sqz;
      BM_SQZ_WELD:  beat_drop = in_sqz || in_weld;
      BM_WAIT_HERE: beat_drop = CYCLE_WAIT_HERE && (in_sqz || in_weld);
      default:      beat_drop = 1'b0;
    endcase
    beat_drop = beat_drop && !init_lvl;
    hv_cond  = VOLT_MON_EN && VOLT_VALID &&
               (VOLT_MEAS > VOLT_HIGH_LIMIT);
    lv_cond  = VOLT_MON_EN && VOLT_VALID &&
               (VOLT_MEAS < VOLT_LOW_LIMIT);
    err_evt  = MAJOR_ERROR || hv_cond || lv_cond ||
               (limit_hit && !s_r.err_pl);
  end

  // sequence, error and output logic
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.prev     = sy;
    s_nxt.weld_pls = 1'b0;
    if (rise[SY_LINE] && s_r.ph_cnt != PH_MAX)
      s_nxt.ph_cnt = PH_W'(s_r.ph_cnt + PH_ONE);
    case (s_r.st)
      ST_IDLE:
      begin
        if ((rise[SY_INIT1] || rise[SY_INIT2]) && !s_r.lockout)
        begin
          s_nxt.src2      = !rise[SY_INIT1];
          s_nxt.valve     = 1'b1;
          s_nxt.imp_cnt   = '0;
          s_nxt.blank_cnt = '0;
          s_nxt.sequence_done_mode       = 1'b0;
          s_nxt.eos_cnt   = '0;
          if (!rise[SY_INIT1])
            s_nxt.sched = SCHED_SECOND;
          else if (SCHED_EXTERNAL)
            s_nxt.sched = SCHED_W'(sy[SY_SEL0 +: 4]);
          else
            s_nxt.sched = PROGRAM_SCHEDULE;
          if (STAGE2_MODE == SS_BEFORE_SQZ)
            s_nxt.st = ST_WAIT_PRE;
          else
            s_nxt.st = ST_SQZ_DELAY;
        end
      end
      ST_WAIT_PRE:
        if (sy[SY_STAGE2])
          s_nxt.st = ST_SQZ_DELAY;
      ST_SQZ_DELAY:
        if (ph_done)
          s_nxt.st = ST_SQUEEZE;
      ST_SQUEEZE:
        if (ph_done)
          s_nxt.st = (STAGE2_MODE == SS_AFTER_SQZ && !sy[SY_STAGE2]) ?
                     ST_WAIT_POST : ST_WELD1;
      ST_WAIT_POST:
        if (sy[SY_STAGE2])
          s_nxt.st = ST_WELD1;
      ST_WELD1:
        if (ph_done)
          s_nxt.st = ST_COOL1;
      ST_COOL1:
        if (ph_done)
          s_nxt.st = ST_WELD2;
      ST_WELD2:
        if (ph_done)
          s_nxt.st = ST_COOL2;
      ST_COOL2:
      begin
        if (ph_done)
        begin
          s_nxt.imp_cnt = PH_W'(s_r.imp_cnt + PH_ONE);
          if (!seam_eff && s_nxt.imp_cnt < IMPULSES)
            s_nxt.st = ST_WELD2;
          else
          begin
            s_nxt.weld_pls = 1'b1;
            s_nxt.imp_cnt  = '0;
            if (!seam_eff)
              s_nxt.st = ST_HOLD;
            else if (init_lvl)
              s_nxt.st = ST_WELD2;
            else
            begin
              s_nxt.st    = ST_IDLE;
              s_nxt.valve = 1'b0;
            end
          end
        end
      end
      ST_HOLD:
      begin
        if (ph_done)
        begin
          s_nxt.st    = ST_OFF;
          s_nxt.valve = 1'b0;
          if (SEQUENCE_DONE_MODE == SD_HANDSHAKE && init_lvl)
            s_nxt.sequence_done_mode = 1'b1;
        end
      end
      ST_OFF:
      begin
        if (ph_done)
        begin
          s_nxt.st = ST_IDLE;
          if (SEQUENCE_DONE_MODE == SD_PULSED && !CHAIN_NEXT)
          begin
            s_nxt.sequence_done_mode     = 1'b1;
            s_nxt.eos_cnt = EOS_W'(EOS_PULSE_CYC - 1);
          end
        end
      end
      ST_HEAD_LOCK:
      begin
        if (rise[SY_ESCAPE])
        begin
          s_nxt.st    = ST_IDLE;
          s_nxt.valve = 1'b0;
        end
      end
      ST_PAUSE:
        if (init_lvl)
          s_nxt.st = s_r.resume;
      default:
        s_nxt.st = ST_IDLE;
    endcase

    // beat release: abort, or pause in wait-here
    if (beat_drop)
    begin
      if (BEAT_MODE == BM_WAIT_HERE)
      begin
        s_nxt.st     = ST_PAUSE;
        s_nxt.resume = s_r.st;
      end
      else
      begin
        s_nxt.st    = ST_IDLE;
        s_nxt.valve = 1'b0;
      end
    end

    // error policy; a new error beats a reset in the same cycle
    if (rise[SY_ERR_RST])
      s_nxt.lockout = 1'b0;
    if (err_evt && ERROR_POLICY != EP_CONTINUE)
      s_nxt.lockout = 1'b1;
    if (err_evt && ERROR_POLICY == EP_HEAD_LOCK && s_r.st != ST_IDLE)
    begin
      s_nxt.st    = ST_HEAD_LOCK;
      s_nxt.valve = 1'b1;
    end

    // sticky error flags, cleared by error reset, set wins
    if (rise[SY_ERR_RST])
    begin
      s_nxt.err_hv = 1'b0;
      s_nxt.err_lv = 1'b0;
      s_nxt.err_pl = 1'b0;
    end
    if (hv_cond)
      s_nxt.err_hv = 1'b1;
    if (lv_cond)
      s_nxt.err_lv = 1'b1;
    if (limit_hit)
      s_nxt.err_pl = 1'b1;

    // done output timing; handshake drops when initiation opens
    if (SEQUENCE_DONE_MODE == SD_HANDSHAKE)
    begin
      if (s_r.sequence_done_mode && !init_lvl)
        s_nxt.sequence_done_mode = 1'b0;
    end
    else if (s_r.sequence_done_mode)
    begin
      if (s_r.eos_cnt == '0)
        s_nxt.sequence_done_mode = 1'b0;
      else
        s_nxt.eos_cnt = EOS_W'(s_r.eos_cnt - 1'b1);
    end

    // weld cycles seen so far, for blanking
    if (rise[SY_LINE] && (s_r.st == ST_WELD1 || s_r.st == ST_WELD2) &&
        s_r.blank_cnt != PH_MAX)
      s_nxt.blank_cnt = PH_W'(s_r.blank_cnt + PH_ONE);

    // retraction; beat mode owns the output and retracts on pause
    if (BEAT_MODE != BM_OFF)
      s_nxt.retract = (s_nxt.st == ST_PAUSE);
    else
      case (RETRACT_MODE)
        RT_MAINTAINED: s_nxt.retract = sy[SY_RETRACT];
        RT_MOMENTARY:
          if (rise[SY_RETRACT])
            s_nxt.retract = !s_r.retract;
        default:       s_nxt.retract = 1'b0;
      endcase

    // each phase starts its timing from zero
    if (s_nxt.st != s_r.st)
      s_nxt.ph_cnt = '0;
  end

  // state register
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      s_r        <= '0;
      s_r.st     <= ST_IDLE;
      s_r.resume <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from state; weld-active and measurement gates are flops too
  logic meas_r;
  logic weld_r;
  always_ff @(posedge REF_CLK)
  begin
    weld_r <= !SYS_RST && (s_nxt.st == ST_WELD1 || s_nxt.st == ST_WELD2);
    meas_r <= !SYS_RST && (s_nxt.st == ST_WELD1 || s_nxt.st == ST_WELD2) &&
              (s_nxt.blank_cnt >= BLANKING_CYC);
  end

  assign VALVE_OUT            = s_r.valve;
  assign RETRACT_OUT          = s_r.retract;
  assign SEQUENCE_DONE_OUTPUT = s_r.sequence_done_mode;
  assign WELD_ACTIVE          = weld_r;
  assign MEAS_ENABLE          = meas_r;
  assign SCHEDULE_NUM         = s_r.sched;
  assign WELD_LOCKOUT         = s_r.lockout;
  assign ERR_HIGH_VOLT        = s_r.err_hv;
  assign ERR_LOW_VOLT         = s_r.err_lv;
  assign ERR_PART_LIMIT       = s_r.err_pl;

endmodule : wss_top

//--- testbench/wss_chk.sv
// port-level assertions for the weld sequence supervisor
`timescale 1ns/1ns
module wss_chk
  import wss_pkg::*;
#(
  parameter int EOS_PULSE_CYC = EOS_CYC_DFLT
)
(
  // clock, reset and watched inputs
  input wire logic                      REF_CLK, SYS_RST, RETRACT_IN,
  input wire logic                      FIRST_INITIATE_INPUT,
  input wire logic                      SECOND_INITIATE_INPUT,
  input wire logic                      VOLT_MON_EN, VOLT_VALID,
  input wire logic                      RST_PART_TALLY,
  input wire logic [9:0]                VOLT_MEAS, VOLT_HIGH_LIMIT,
  input wire wss_pkg::wss_retract_mode_t RETRACT_MODE,
  input wire wss_pkg::wss_beat_mode_t   BEAT_MODE,
  input wire wss_pkg::wss_stage2_mode_t STAGE2_MODE,
  input wire wss_pkg::wss_done_mode_t   SEQUENCE_DONE_MODE,
  // watched outputs
  input wire logic                      VALVE_OUT, RETRACT_OUT, WELD_ACTIVE,
  input wire logic                      SEQUENCE_DONE_OUTPUT, WELD_LOCKOUT,
  input wire logic                      ERR_HIGH_VOLT,
  input wire logic [5:0]                SCHEDULE_NUM,
  input wire logic [15:0]               PART_TALLY,
  input wire logic [13:0]               WELDS_PER_PART_TALLY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  int hi_len;
  // length of the present high run on the done output
  always_ff @(posedge REF_CLK)
    hi_len <= (SYS_RST || !SEQUENCE_DONE_OUTPUT) ? 0 : hi_len + 1;
  // a plain start must reach a weld phase while all times are short
  sequence s_start;
    $rose(VALVE_OUT) && BEAT_MODE == BM_OFF && STAGE2_MODE == SS_NONE;
  endsequence
  sequence s_weld;
    ##[1:60] WELD_ACTIVE;
  endsequence
  AST_SPOT_RUN: assert property (s_start |-> s_weld)
    else $error("spot run lost");
  AST_DONE_LEN: assert property ($fell(SEQUENCE_DONE_OUTPUT) &&
    SEQUENCE_DONE_MODE == SD_PULSED |-> hi_len == EOS_PULSE_CYC)
    else $error("done pulse length");
  AST_SECOND_SCHED: assert property ($rose(VALVE_OUT) &&
    $past(SECOND_INITIATE_INPUT, 2) && !$past(FIRST_INITIATE_INPUT, 2)
    |-> ##[0:1] SCHEDULE_NUM == SCHED_SECOND) else $error("second sched");
  AST_LOCK_REFUSE: assert property (WELD_LOCKOUT && !VALVE_OUT
    ##1 WELD_LOCKOUT |-> !VALVE_OUT) else $error("locked weld began");
  AST_RETRACT_FOLLOW: assert property (RETRACT_MODE == RT_MAINTAINED &&
    BEAT_MODE == BM_OFF && $rose(RETRACT_IN) |-> ##[2:4] RETRACT_OUT)
    else $error("retract not followed");
  AST_HIGH_VOLT: assert property (VOLT_MON_EN && VOLT_VALID &&
    VOLT_MEAS > VOLT_HIGH_LIMIT |-> ##[1:2] ERR_HIGH_VOLT)
    else $error("high volt missed");
  AST_PART_STEP: assert property ($changed(PART_TALLY) &&
    !$past(RST_PART_TALLY) |-> PART_TALLY == $past(PART_TALLY) + 16'h0001
    && WELDS_PER_PART_TALLY == 14'h0000) else $error("part step");
  AST_WELD_STEP: assert property ($changed(WELDS_PER_PART_TALLY) &&
    WELDS_PER_PART_TALLY != 14'h0000 |-> WELDS_PER_PART_TALLY ==
    $past(WELDS_PER_PART_TALLY) + 14'h0001) else $error("weld step");
endmodule : wss_chk
bind wss_top wss_chk #(.EOS_PULSE_CYC(EOS_PULSE_CYC)) wss_chk_inst (.*);

//--- testbench/wss_partner.sv
// operator switch and free-running mains line model
`timescale 1ns/1ns
module wss_partner (
  // bench side
  input  wire logic clk, press, sel,
  input  var  int   len,
  // pins toward the supervisor
  output logic      init1, init2, line
);
  int c = 0;
  int h = 0;
  initial {init1, init2, line} = 3'h0;
  // mains never stops, one line-cycle rise every five clocks
  always @(negedge clk)
  begin
    c <= (c == 4) ? 0 : c + 1;
    line <= (c == 4);
    // a pressed switch stays closed for len clocks
    init1 <= h != 0 && !sel;
    init2 <= h != 0 && sel;
  end
  // press taken mid-cycle, away from the bench's drive edge
  always @(posedge clk)
    h <= (press && h == 0) ? len : (h != 0) ? h - 1 : 0;
endmodule : wss_partner

//--- testbench/wss_top_tb.sv
// self-checking bench for the weld sequence supervisor
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module wss_top_tb;
  import wss_pkg::*;
  logic REF_CLK = 0, SYS_RST = 1, SECOND_STAGE_IN = 0, ESCAPE_IN = 0;
  logic RETRACT_IN = 0, ERROR_RESET_IN = 0, SCHED_EXTERNAL = 0;
  logic SCHEDULE_SELECT_BIT0 = 0, SCHEDULE_SELECT_BIT1 = 0;
  logic SCHEDULE_SELECT_BIT2 = 0, SCHEDULE_SELECT_BIT3 = 0;
  logic CYCLE_WAIT_HERE = 0, CHAIN_NEXT = 0, VOLT_MON_EN = 0, VOLT_VALID = 0;
  logic MAJOR_ERROR = 0, COUNTER_EN = 1, RST_PART_TALLY = 0;
  logic RST_WELD_TALLY = 0, FIRST_INITIATE_INPUT, SECOND_INITIATE_INPUT;
  logic LINE_CYCLE_IN, VALVE_OUT, RETRACT_OUT, SEQUENCE_DONE_OUTPUT;
  logic WELD_ACTIVE, MEAS_ENABLE, WELD_LOCKOUT, ERR_HIGH_VOLT, ERR_LOW_VOLT;
  logic ERR_PART_LIMIT, v_q = 0, wa = 0, press = 0, p_sel = 0;
  wss_weld_mode_t    WELD_MODE = WM_SPOT;
  wss_retract_mode_t RETRACT_MODE = RT_OFF;
  wss_err_policy_t   ERROR_POLICY = EP_CONTINUE;
  wss_stage2_mode_t  STAGE2_MODE = SS_NONE;
  wss_beat_mode_t    BEAT_MODE = BM_OFF;
  wss_done_mode_t    SEQUENCE_DONE_MODE = SD_PULSED;
  logic [5:0] PROGRAM_SCHEDULE = '0, SCHEDULE_NUM, e, exp_q[$];
  logic [6:0] SQZ_DELAY_CYC = '0, SQUEEZE_CYC = '0, WELD1_CYC = '0;
  logic [6:0] COOL1_CYC = '0, WELD2_CYC = '0, COOL2_CYC = '0, HOLD_CYC = '0;
  logic [6:0] OFF_CYC = '0, IMPULSES = 7'h01, BLANKING_CYC = '0;
  logic [9:0] VOLT_HIGH_LIMIT = VOLT_HIGH_DFLT, VOLT_MEAS = '0;
  logic [9:0] VOLT_LOW_LIMIT = VOLT_LOW_DFLT;
  logic [15:0] PART_LIMIT = 16'h0003, PART_TALLY;
  logic [13:0] WELDS_PER_PART = 14'h0002, WELDS_PER_PART_TALLY;
  logic [3:0] sel;
  int num_errors = 0, check_count = 0, cyc = 0, p_len = 0;

  wss_top #(.EOS_PULSE_CYC(8)) wss_top_inst (.*);
  wss_partner wss_partner_inst (.clk(REF_CLK), .press(press), .sel(p_sel),
    .len(p_len), .init1(FIRST_INITIATE_INPUT),
    .init2(SECOND_INITIATE_INPUT), .line(LINE_CYCLE_IN));

  initial forever #5 REF_CLK = ~REF_CLK;

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // scoreboard: each new valve start takes the oldest note; hang guard
  always @(posedge REF_CLK)
  begin
    v_q <= VALVE_OUT;
    wa <= wa | WELD_ACTIVE;
    cyc <= cyc + 1;
    if (BLANKING_CYC == 0) `CHK("meas", WELD_ACTIVE, MEAS_ENABLE)
    if (VALVE_OUT && !v_q)
    begin
      e = exp_q.pop_front();
      `CHK("schedule", e, SCHEDULE_NUM)
    end
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test;
    end
  end

  // press a switch, note the schedule if a start is due, wait it out
  task automatic run(input bit s, input int len, input logic [5:0] x,
                     input bit ok);
    if (ok) exp_q.push_back(x);
    press = 1;
    p_sel = s;
    p_len = len;
    @(negedge REF_CLK);
    press = 0;
    repeat (20) if (!VALVE_OUT) @(negedge REF_CLK);
    repeat (500) if (VALVE_OUT) @(negedge REF_CLK);
    repeat (len + 14) @(negedge REF_CLK);
  endtask : run

  // error reset pin pulse, long enough to pass the synchroniser
  task err_rst;
    ERROR_RESET_IN = 1;
    repeat (4) @(negedge REF_CLK);
    ERROR_RESET_IN = 0;
    repeat (4) @(negedge REF_CLK);
  endtask : err_rst

  initial
  begin
    void'($urandom(32'hCAE7782A));
    repeat (2) @(negedge REF_CLK);
    SYS_RST = 0;
    `CHK("tally", 16'h0000, PART_TALLY)
    for (int i = 0; i < 6; i++)
    begin
      sel = 4'($urandom);
      {SCHEDULE_SELECT_BIT3, SCHEDULE_SELECT_BIT2} = sel[3:2];
      {SCHEDULE_SELECT_BIT1, SCHEDULE_SELECT_BIT0} = sel[1:0];
      PROGRAM_SCHEDULE = 6'($urandom);
      SCHED_EXTERNAL = i[0];
      WELD_MODE = i == 5 ? WM_SEAM_B : WM_SPOT;
      IMPULSES = 7'(1 + $urandom % 3);
      BLANKING_CYC = 7'($urandom % 4);
      {CYCLE_WAIT_HERE, SECOND_STAGE_IN} = 2'($urandom);
      run(i == 5, 6, i == 5 ? SCHED_SECOND :
          i[0] ? {2'h0, sel} : PROGRAM_SCHEDULE, 1);
    end
    `CHK("parts", 16'h0003, PART_TALLY)
    `CHK("welds", 14'h0000, WELDS_PER_PART_TALLY)
    `CHK("part limit", 1'b1, ERR_PART_LIMIT)
    $display("test schedule and tally ended");
    PART_LIMIT = PART_LIMIT_DFLT;
    SCHED_EXTERNAL = 0;
    WELD_MODE = WM_SPOT;
    VOLT_MON_EN = 1;
    for (int k = 0; k < 2; k++)
    begin
      VOLT_MEAS = k ? 10'($urandom % 160) : 10'(691 + $urandom % 300);
      VOLT_VALID = 1;
      @(negedge REF_CLK);
      VOLT_VALID = 0;
      repeat (3) @(negedge REF_CLK);
    end
    `CHK("high volt", 1'b1, ERR_HIGH_VOLT)
    `CHK("low volt", 1'b1, ERR_LOW_VOLT)
    VOLT_MON_EN = 0;
    err_rst;
    `CHK("flags", 3'h0,
         {ERR_HIGH_VOLT, ERR_LOW_VOLT, ERR_PART_LIMIT})
    {RST_PART_TALLY, RST_WELD_TALLY} = 2'h3;
    @(negedge REF_CLK);
    {RST_PART_TALLY, RST_WELD_TALLY} = 2'h0;
    @(negedge REF_CLK);
    `CHK("cleared", 30'h0, {PART_TALLY, WELDS_PER_PART_TALLY})
    $display("test voltage and clear ended");
    ERROR_POLICY = EP_STOP;
    MAJOR_ERROR = 1;
    @(negedge REF_CLK);
    MAJOR_ERROR = 0;
    run(0, 6, PROGRAM_SCHEDULE, 0);
    `CHK("lockout", 1'b1, WELD_LOCKOUT)
    err_rst;
    `CHK("unlocked", 1'b0, WELD_LOCKOUT)
    run(0, 6, PROGRAM_SCHEDULE, 1);
    ERROR_POLICY = EP_HEAD_LOCK;
    HOLD_CYC = 7'h14;
    fork
      run(0, 6, PROGRAM_SCHEDULE, 1);
      begin
        repeat (20) @(negedge REF_CLK);
        MAJOR_ERROR = 1;
        @(negedge REF_CLK);
        MAJOR_ERROR = 0;
        repeat (200) @(negedge REF_CLK);
        `CHK("valve held", 1'b1, VALVE_OUT)
        ESCAPE_IN = 1;
        repeat (4) @(negedge REF_CLK);
        ESCAPE_IN = 0;
      end
    join
    `CHK("valve freed", 1'b0, VALVE_OUT)
    err_rst;
    {HOLD_CYC, ERROR_POLICY} = {7'h00, EP_CONTINUE};
    $display("test error policies ended");
    RETRACT_MODE = RT_MAINTAINED;
    for (int k = 1; k < 8; k++)
    begin
      if (k == 3) RETRACT_MODE = RT_MOMENTARY;
      if (k == 7) BEAT_MODE = BM_SQUEEZE;
      RETRACT_IN = 1;
      repeat (5) @(negedge REF_CLK);
      if (k < 3) `CHK("follow", 1'b1, RETRACT_OUT)
      RETRACT_IN = 0;
      repeat (5) @(negedge REF_CLK);
      `CHK("retract", k > 2 && k < 7 && k[0], RETRACT_OUT)
    end
    $display("test retraction ended");
    SQUEEZE_CYC = 7'h14;
    for (int k = 0; k < 4; k++)
    begin
      BEAT_MODE = k[1] ? BM_SQZ_WELD : BM_SQUEEZE;
      wa = 0;
      run(0, k[0] ? 200 : 10, PROGRAM_SCHEDULE, 1);
      `CHK("weld reached", k[0], wa)
    end
    $display("test beat ended");
    finish_test;
  end
endmodule : wss_top_tb
